// *** hw/asl_params.svh ***
/*
 * Constants for the algorithm security lock: key layout, SPI timing,
 * debug-port command codes and widths.
 * Assumes a single 40 MHz system clock and an external SPI serial EEPROM.
 */
// Overview of operation
// [R1] Locked: block external memory and EEPROM access
// [R2] Unlocked: allow external memory and EEPROM access
// [R3] Decrypt encrypted sections with internal keys
// [R4] Key storage unreadable while access restricted
// [R5] External unlock erases stored decryption keys
// [R6] Host rewrites keys after unlock
// [R7] Glueless SPI EEPROM fetch of code/data
// [R8] Key clearing completes before access granted
`ifndef ASL_PARAMS_SVH
`define ASL_PARAMS_SVH

`define ASL_KEY_WORDS 4
`define ASL_KEY_IDX_W 2
`define ASL_KEY_LAST 2'h3
`define ASL_WORD_W 32
`define ASL_ADDR_W 24
`define ASL_SPI_READ_CMD 8'h03
`define ASL_SPI_HALF_NS 50
`define ASL_CLK_NS 25
`define ASL_SPI_HALF_CYC ((`ASL_SPI_HALF_NS + `ASL_CLK_NS - 1) / `ASL_CLK_NS)
`define ASL_DIV_W 4
`define ASL_BITS_W 7
`define ASL_FETCH_BITS 7'h40
`define ASL_DATA_BITS 6'h20
`define ASL_CMD_NONE 3'h0
`define ASL_CMD_UNLOCK 3'h1
`define ASL_CMD_LOCK 3'h2
`define ASL_CMD_KEY_WR 3'h3
`define ASL_CMD_KEY_RD 3'h4
`define ASL_CMD_MEM_RD 3'h5
`define ASL_CMD_EE_RD 3'h6
`define ASL_ZERO_WORD 32'h0000_0000

`endif

// *** hw/asl_pkg.sv ***
/*
 * Types for the algorithm security lock.
 * Assumes asl_params.svh is included by every user.
 */
`include "asl_params.svh"
package asl_pkg;
  typedef enum logic [4:0] {
    ASL_LOCKED = 5'h01,
    ASL_CLEARING = 5'h02,
    ASL_OPEN = 5'h04,
    ASL_FETCH = 5'h08,
    ASL_WAIT = 5'h10
  } asl_state_t;

  typedef struct packed {
    logic valid;
    logic [2:0] cmd;
    logic [`ASL_ADDR_W-1:0] addr;
    logic [`ASL_WORD_W-1:0] data;
  } asl_req_t;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [`ASL_WORD_W-1:0] data;
  } asl_rsp_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } asl_spi_t;
endpackage

// *** hw/asl_spi_fetch.sv ***
/*
 * SPI EEPROM word fetcher: issues a read command and address, returns
 * one 32-bit word. Direct pin connection to a mode-0 serial EEPROM.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asl_params.svh"
module asl_spi_fetch (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [`ASL_ADDR_W-1:0] addr,
  input wire logic miso,
  output asl_pkg::asl_spi_t spi,
  output logic done,
  output logic [`ASL_WORD_W-1:0] word
);
  typedef struct packed {
    logic busy;
    logic [`ASL_DIV_W-1:0] div;
    logic [`ASL_BITS_W-1:0] bits;
    logic [`ASL_FETCH_BITS-1:0] shreg;
    logic [`ASL_WORD_W-1:0] rx;
    asl_pkg::asl_spi_t spi;
    logic done;
  } asl_fetch_state_t;

  asl_fetch_state_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (!st.busy) begin
      if (start) begin // [R7]
        next_st.busy = 1'b1;
        next_st.spi.cs_n = 1'b0;
        next_st.shreg = {`ASL_SPI_READ_CMD, addr, `ASL_ZERO_WORD};
        next_st.spi.mosi = next_st.shreg[`ASL_FETCH_BITS-1];
        next_st.bits = `ASL_FETCH_BITS;
        next_st.div = '0;
      end
    end else if (st.div == `ASL_DIV_W'(`ASL_SPI_HALF_CYC - 1)) begin
      next_st.div = '0;
      if (!st.spi.sck) begin
        next_st.spi.sck = 1'b1;
        next_st.rx = {st.rx[`ASL_WORD_W-2:0], miso};
        next_st.bits = st.bits - 1'b1;
      end else begin
        next_st.spi.sck = 1'b0;
        next_st.shreg = {st.shreg[`ASL_FETCH_BITS-2:0], 1'b0};
        next_st.spi.mosi = st.shreg[`ASL_FETCH_BITS-2];
        if (st.bits == '0) begin
          next_st.busy = 1'b0;
          next_st.spi.cs_n = 1'b1;
          next_st.done = 1'b1;
        end
      end
    end else begin
      next_st.div = st.div + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.spi.cs_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign spi = st.spi;
  assign done = st.done;
  assign word = st.rx;
endmodule
`default_nettype wire

// *** hw/asl_lock.sv ***
/*
 * Algorithm security lock: gates debug-port access to on-chip memory,
 * the SPI EEPROM and the key store, erases keys on unlock and decrypts
 * fetched words with the held keys.
 * Assumes a debug port issuing one request at a time and an on-chip
 * memory answering reads in one cycle; the cipher is the internal key mix.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asl_params.svh"
module asl_lock (
  input wire logic sys_clk,
  input wire logic rst,
  input wire asl_pkg::asl_req_t req,
  output asl_pkg::asl_rsp_t rsp,
  output logic mem_rd,
  output logic [`ASL_ADDR_W-1:0] mem_addr,
  input wire logic [`ASL_WORD_W-1:0] mem_rdata,
  input wire logic miso,
  output asl_pkg::asl_spi_t spi,
  output logic [`ASL_WORD_W-1:0] plain_word,
  output logic plain_valid,
  output logic locked
);
  typedef struct packed {
    asl_pkg::asl_state_t fsm;
    logic [`ASL_KEY_IDX_W-1:0] clr_idx;
    logic [`ASL_KEY_WORDS-1:0][`ASL_WORD_W-1:0] key;
    logic ee_host;
    logic start;
    logic [`ASL_ADDR_W-1:0] addr;
    asl_pkg::asl_rsp_t rsp;
    logic mem_rd;
    logic mem_pend;
    logic [`ASL_WORD_W-1:0] plain;
    logic plain_valid;
    logic locked;
  } asl_lock_state_t;

  asl_lock_state_t st, next_st;
  logic f_done;
  logic [`ASL_WORD_W-1:0] f_word;

  function automatic logic [`ASL_WORD_W-1:0] asl_key_mix(
    input logic [`ASL_KEY_WORDS-1:0][`ASL_WORD_W-1:0] k,
    input logic [`ASL_ADDR_W-1:0] a);
    logic [`ASL_WORD_W-1:0] m;
    m = {8'h00, a};
    for (int i = 0; i < `ASL_KEY_WORDS; i++) begin
      m = {m[`ASL_WORD_W-2:0], m[`ASL_WORD_W-1]} ^ k[i];
    end
    return m;
  endfunction

  asl_spi_fetch u_fetch (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(st.start),
    .addr(st.addr),
    .miso(miso),
    .spi(spi),
    .done(f_done),
    .word(f_word)
  );

  always_comb begin
    next_st = st;
    next_st.rsp = '0;
    next_st.start = 1'b0;
    next_st.mem_rd = 1'b0;
    next_st.mem_pend = st.mem_rd;
    next_st.plain_valid = 1'b0;
    if (st.mem_pend) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data = mem_rdata;
    end
    case (st.fsm)
      asl_pkg::ASL_LOCKED: begin
        if (req.valid) begin
          next_st.rsp.valid = 1'b1;
          if (req.cmd == `ASL_CMD_UNLOCK) begin
            next_st.fsm = asl_pkg::ASL_CLEARING; // [R5]
            next_st.clr_idx = '0;
            next_st.rsp.valid = 1'b0;
          end else if (req.cmd == `ASL_CMD_KEY_WR) begin
            next_st.key[req.addr[`ASL_KEY_IDX_W-1:0]] = req.data;
          end else begin
            next_st.rsp.denied = 1'b1; // [R1] [R4]
          end
        end
      end
      asl_pkg::ASL_CLEARING: begin
        next_st.key[st.clr_idx] = `ASL_ZERO_WORD; // [R5]
        next_st.clr_idx = st.clr_idx + 1'b1;
        if (st.clr_idx == `ASL_KEY_LAST) begin
          next_st.fsm = asl_pkg::ASL_OPEN; // [R8]
          next_st.rsp.valid = 1'b1;
        end
      end
      asl_pkg::ASL_OPEN: begin
        if (req.valid) begin // [R2]
          case (req.cmd)
            `ASL_CMD_LOCK: begin
              next_st.fsm = asl_pkg::ASL_LOCKED;
              next_st.rsp.valid = 1'b1;
            end
            `ASL_CMD_KEY_WR: begin
              next_st.key[req.addr[`ASL_KEY_IDX_W-1:0]] = req.data;
              next_st.rsp.valid = 1'b1;
            end
            `ASL_CMD_KEY_RD: begin
              next_st.rsp.valid = 1'b1;
              next_st.rsp.data = st.key[req.addr[`ASL_KEY_IDX_W-1:0]];
            end
            `ASL_CMD_MEM_RD: begin
              next_st.mem_rd = 1'b1;
              next_st.addr = req.addr;
            end
            `ASL_CMD_EE_RD: begin
              next_st.fsm = asl_pkg::ASL_FETCH;
              next_st.addr = req.addr;
              next_st.ee_host = 1'b1;
            end
            default: begin
              next_st.rsp.valid = 1'b1;
            end
          endcase
        end
      end
      asl_pkg::ASL_FETCH: begin
        next_st.start = 1'b1; // [R7]
        next_st.fsm = asl_pkg::ASL_WAIT;
      end
      asl_pkg::ASL_WAIT: begin
        if (f_done) begin
          next_st.fsm = asl_pkg::ASL_OPEN;
          next_st.ee_host = 1'b0;
          next_st.rsp.valid = 1'b1;
          next_st.rsp.data = f_word;
          next_st.plain_valid = 1'b1;
          next_st.plain = f_word ^ asl_key_mix(st.key, st.addr); // [R3]
        end
      end
      default: begin
        next_st.fsm = asl_pkg::ASL_LOCKED;
      end
    endcase
    // Registered so the pin comes straight from a flip-flop
    next_st.locked = (next_st.fsm == asl_pkg::ASL_LOCKED) ||
                     (next_st.fsm == asl_pkg::ASL_CLEARING); // [R1]
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.fsm <= asl_pkg::ASL_LOCKED;
      st.locked <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
  assign mem_rd = st.mem_rd;
  assign mem_addr = st.addr;
  assign plain_word = st.plain;
  assign plain_valid = st.plain_valid;
  assign locked = st.locked;
endmodule
`default_nettype wire

// *** bench/asl_ee_model.sv ***
/* Serial EEPROM model, mode 0, answering reads with an address pattern.
   Assumes one device on the lock's SPI pins. */
`timescale 1ns/1ps
`default_nettype none
module asl_ee_model (
  input wire asl_pkg::asl_spi_t spi,
  output logic miso
);
  logic [31:0] sr;
  logic [31:0] w;
  int n;
  initial begin
    miso = 1'b0;
    n = 0;
  end
  always @(negedge spi.cs_n) n = 0;
  always @(posedge spi.sck) if (!spi.cs_n) begin
    sr = {sr[30:0], spi.mosi};
    n = n + 1;
  end
  // Wrong command byte corrupts the word
  always @(negedge spi.sck) if (!spi.cs_n && n >= 32 && n < 64) begin
    if (n == 32) w = {sr[7:0] ^ sr[31:24] ^ 8'h03, sr[23:0]} ^ 32'h5aa55aa5;
    miso <= w[63-n];
  end
  always @(posedge spi.cs_n) miso <= ~miso;
endmodule
`default_nettype wire

// *** bench/asl_chk.sv ***
/* Port checker for asl_lock.
   Assumes one clock, asynchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
`include "asl_params.svh"
module asl_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire asl_pkg::asl_req_t req,
  input wire asl_pkg::asl_rsp_t rsp,
  input wire logic mem_rd,
  input wire logic [`ASL_ADDR_W-1:0] mem_addr,
  input wire logic [`ASL_WORD_W-1:0] mem_rdata,
  input wire logic miso,
  input wire asl_pkg::asl_spi_t spi,
  input wire logic [`ASL_WORD_W-1:0] plain_word,
  input wire logic plain_valid,
  input wire logic locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_unlock;
    req.valid && req.cmd == `ASL_CMD_UNLOCK && locked;
  endsequence
  sequence s_clear;
    locked [*4] ##1 (!locked && rsp.valid);
  endsequence
  sequence s_mem;
    req.valid && req.cmd == `ASL_CMD_MEM_RD && !locked && spi.cs_n;
  endsequence
  AST_LOCK_MEM: assert property (locked |-> !mem_rd)
    else $error("memory read while locked");
  AST_LOCK_SPI: assert property (locked |-> spi.cs_n)
    else $error("eeprom selected while locked");
  AST_UNLOCK: assert property (s_unlock |=> s_clear)
    else $error("unlock sequence wrong");
  AST_MEM: assert property (s_mem |=>
    mem_rd && mem_addr == $past(req.addr)
    ##2 rsp.valid && rsp.data == $past(mem_rdata))
    else $error("open memory read wrong");
  AST_MEM_ONLY: assert property (mem_rd |->
    $past(req.valid && req.cmd == `ASL_CMD_MEM_RD && !locked))
    else $error("memory read not requested");
  AST_KEY_LOCKED: assert property (rsp.valid &&
    $past(locked && req.valid && req.cmd == `ASL_CMD_KEY_RD) |-> rsp.denied)
    else $error("key read not denied");
  AST_SCK_IDLE: assert property (spi.cs_n |-> !spi.sck)
    else $error("sck not idle low");
  AST_PLAIN_OPEN: assert property (plain_valid |-> !locked)
    else $error("plain word while locked");
endmodule
bind asl_lock asl_chk u_chk (.sys_clk(sys_clk), .rst(rst), .req(req),
  .rsp(rsp), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
  .miso(miso), .spi(spi), .plain_word(plain_word),
  .plain_valid(plain_valid), .locked(locked));
`default_nettype wire

// *** bench/tb.sv ***
/* Self-checking bench for asl_lock with a serial EEPROM model.
   Assumes the lock answers one request at a time. */
`timescale 1ns/1ps
`default_nettype none
`include "asl_params.svh"
`define CK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
  logic sys_clk, rst, miso, plain_valid, locked, mem_rd;
  asl_pkg::asl_req_t req;
  asl_pkg::asl_rsp_t rsp;
  asl_pkg::asl_spi_t spi;
  logic [`ASL_ADDR_W-1:0] mem_addr, a;
  logic [`ASL_WORD_W-1:0] mem_rdata, plain_word, pw, d;
  logic [`ASL_WORD_W-1:0] mk [4];
  int n_fail, n_compared, lat, i;
  asl_lock u_dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .miso(miso), .spi(spi), .plain_word(plain_word),
    .plain_valid(plain_valid), .locked(locked));
  asl_ee_model u_ee (.spi(spi), .miso(miso));
  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (plain_valid === 1'b1) pw <= plain_word;
  task op(input logic [2:0] c, input logic [23:0] ad, input logic [31:0] dt);
    @(negedge sys_clk);
    req <= '{1'b1, c, ad, dt};
    @(negedge sys_clk);
    req.valid <= 1'b0;
    lat = 1;
    while (rsp.valid !== 1'b1 && lat < 400) begin
      @(negedge sys_clk);
      lat++;
    end
    if (lat >= 400) begin
      n_fail++;
      $display("mismatch answer exp 1 got 0");
    end
  endtask
  // Key mix over the address: rotate left, xor each key word in turn
  function automatic logic [31:0] mix(input logic [23:0] ad);
    logic [31:0] m;
    m = {8'h00, ad};
    for (int k = 0; k < 4; k++) begin
      m = {m[30:0], m[31]} ^ mk[k];
    end
    return m;
  endfunction
  task ee_rd;
    a = 24'($urandom);
    d = {a[7:0], a} ^ 32'h5aa55aa5;
    op(`ASL_CMD_EE_RD, a, '0);
    `CK("eeprom word", d, rsp.data)
    @(negedge sys_clk);
    `CK("plain word", d ^ mix(a), pw)
  endtask
  task stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 0; rst = 1; req = '0; mem_rdata = '0;
    n_fail = 0; n_compared = 0;
    void'($urandom(59));
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rst = 0;
    `CK("locked", 1'b1, locked)
    for (i = 2; i < 8; i++) begin
      if (i != `ASL_CMD_KEY_WR) begin
        a = 24'($urandom);
        op(3'(i), a, '0);
        `CK("denied", 1'b1, rsp.denied)
        `CK("denied data", 32'h0, rsp.data)
      end
    end
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      op(`ASL_CMD_KEY_WR, 24'(i), d);
      `CK("key write", 1'b0, rsp.denied)
    end
    $display("end locked test");
    mk = '{default: '0};
    op(`ASL_CMD_UNLOCK, '0, '0);
    `CK("unlock cycles", 5, lat)
    `CK("locked", 1'b0, locked)
    for (i = 0; i < 4; i++) begin
      op(`ASL_CMD_KEY_RD, 24'(i), '0);
      `CK("cleared key", mk[i], rsp.data)
    end
    mem_rdata = $urandom;
    a = 24'($urandom);
    op(`ASL_CMD_MEM_RD, a, '0);
    `CK("mem data", mem_rdata, rsp.data)
    `CK("mem cycles", 3, lat)
    `CK("mem addr", a, mem_addr)
    ee_rd;
    $display("end unlock test");
    for (i = 0; i < 4; i++) begin
      mk[i] = $urandom;
      op(`ASL_CMD_KEY_WR, 24'(i), mk[i]);
      op(`ASL_CMD_KEY_RD, 24'(i), '0);
      `CK("new key", mk[i], rsp.data)
    end
    ee_rd;
    op(`ASL_CMD_LOCK, '0, '0);
    `CK("relocked", 1'b1, locked)
    op(`ASL_CMD_KEY_RD, '0, '0);
    `CK("key hidden", 1'b1, rsp.denied)
    $display("end relock test");
    stop_test;
  end
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule
`default_nettype wire
